// ===== logic/xbc_ext_bus_unit.sv
// External bus unit: runs CPU accesses on external memory and peripherals,
// with windowed bus configurations, chip selects and hold arbitration.
// Assumes the CPU holds its request until done, and pins feed the bus pins.
//
// Operation
// - Single chip mode refuses external accesses; otherwise external modes apply.
// - Each window selects multiplexed or not and 8- or 16-bit data; the address space is set for all windows.
// - Demultiplexed: address on address port, data on data port, low byte when 8-bit.
// - Multiplexed: data port carries address phase then data phase.
// - Cycle time, tri-state time, ALE length and strobe delay are programmable.
// - Four address windows, each with range and configuration.
// - Window four beats three, window two beats one on overlap.
// - Addresses outside every window use the default configuration.
// - Five active-low chip selects: one per window plus default.
// - Ready polarity per window; enabled cycles end on the active ready level.
// - Arbitration enable hands request, acknowledge and hold pins to this unit.
// - After reset the unit is arbitration master driving the acknowledge pin.
// - Request pin direction one selects slave mode; acknowledge becomes input.
// - Address space 16M, 1M, 256K or 64K drives 8, 4, 2 or 0 segment lines.
// - By default chip selects change one CPU clock after ALE rises, half a clock rounded up.
// - With the timing bit set chip selects change with ALE rising.
module xbc_ext_bus_unit
    import xbc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic cpu_req,
    input wire logic cpu_write,
    input wire logic [ADDR_W-1:0] cpu_addr,
    input wire logic [DATA_W-1:0] cpu_wdata,
    output logic [DATA_W-1:0] cpu_rdata,
    output logic cpu_done,
    output logic cpu_error,
    input wire logic single_chip,
    input wire logic [1:0] addr_space,
    input wire logic chip_select_timing_bit,
    input wire logic arbitration_enable,
    input wire logic request_pin_direction,
    input wire logic [WIN_N-1:0][ADDR_W-1:0] window_range_select,
    input wire logic [WIN_N-1:0][CFG_W-1:0] window_bus_config,
    input wire logic [CFG_W-1:0] default_bus_config,
    input wire logic [DATA_W-1:0] data_port_in,
    output logic [DATA_W-1:0] data_port_out,
    output logic [1:0] data_port_oe,
    output logic [DATA_W-1:0] address_port_out,
    output logic address_port_oe,
    output logic [SEG_W-1:0] segment_out,
    output logic ale,
    output logic rd_n,
    output logic wr_n,
    output logic [CS_W-1:0] chip_select_lines_n,
    output logic control_oe,
    input wire logic ready_pin,
    input wire logic hold_n,
    output logic bus_request_pin_n,
    input wire logic hold_ack_pin_in_n,
    output logic hold_ack_pin_out_n,
    output logic hold_ack_pin_oe,
    output logic bus_held
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    xbc_state_t state;
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    logic [DATA_W-1:0] data_sync;
    logic ready_sync;
    logic hold_sync_n;
    logic ack_sync_n;
    logic [CFG_W-1:0] dec_config;
    logic [CS_W-1:0] dec_cs;
    logic [CFG_W-1:0] cfg;
    logic [CS_W-1:0] cs_sel;
    logic cs_pending;
    logic wr_cycle;
    logic [DATA_W-1:0] wdata;
    logic [CNT_W-1:0] cnt;
    logic strobe_dly;
    logic arb_master;
    logic arb_slave;
    logic hold_wanted;
    logic [SEG_W-1:0] seg_mask;

    // Data is synchronised too, so wait states must cover two extra cycles.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {ready_pin, hold_n, hold_ack_pin_in_n, data_port_in};
            sync_b <= sync_a;
        end
    end

    assign data_sync = sync_b[DATA_W-1:0];
    assign ack_sync_n = sync_b[DATA_W];
    assign hold_sync_n = sync_b[DATA_W+1];
    assign ready_sync = sync_b[DATA_W+2];

    xbc_window_decode u_decode (
        .addr(cpu_addr),
        .window_range_select(window_range_select),
        .window_bus_config(window_bus_config),
        .default_bus_config(default_bus_config),
        .sel_config(dec_config),
        .sel_cs(dec_cs)
    );

    // ------------------------------------------------------------------
    // Arbitration role and address space
    // ------------------------------------------------------------------
    assign arb_master = arbitration_enable && !request_pin_direction;
    assign arb_slave = arbitration_enable && request_pin_direction;
    assign hold_wanted = (arb_master && !hold_sync_n) || (arb_slave && ack_sync_n);

    always_comb begin
        case (addr_space)
            SPACE_16M: seg_mask = SEG_MASK_16M;
            SPACE_1M: seg_mask = SEG_MASK_1M;
            SPACE_256K: seg_mask = SEG_MASK_256K;
            SPACE_64K: seg_mask = SEG_MASK_64K;
            default: seg_mask = SEG_MASK_64K;
        endcase
    end

    // The acknowledge pin direction follows the role at all times.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hold_ack_pin_oe <= 1'b1;
        end else begin
            hold_ack_pin_oe <= !arb_slave;
        end
    end

    // ------------------------------------------------------------------
    // Bus cycle sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= ST_IDLE;
            cfg <= '0;
            cs_sel <= '0;
            cs_pending <= 1'b0;
            wr_cycle <= 1'b0;
            wdata <= '0;
            cnt <= ZERO_CYC;
            strobe_dly <= 1'b0;
            cpu_rdata <= '0;
            cpu_done <= 1'b0;
            cpu_error <= 1'b0;
            data_port_out <= '0;
            data_port_oe <= 2'h0;
            address_port_out <= '0;
            address_port_oe <= 1'b1;
            segment_out <= '0;
            ale <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            chip_select_lines_n <= '1;
            control_oe <= 1'b1;
            bus_request_pin_n <= 1'b1;
            hold_ack_pin_out_n <= 1'b1;
            bus_held <= 1'b0;
        end else begin
            cpu_done <= 1'b0;
            cpu_error <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (hold_wanted) begin
                        // Hold is only entered between cycles, never inside one.
                        state <= ST_HOLD;
                        address_port_oe <= 1'b0;
                        control_oe <= 1'b0;
                        data_port_oe <= 2'h0;
                        bus_held <= 1'b1;
                        hold_ack_pin_out_n <= !arb_master;
                        bus_request_pin_n <= !(arb_slave && cpu_req);
                    end else if (cpu_req && single_chip) begin
                        cpu_done <= 1'b1;
                        cpu_error <= 1'b1;
                    end else if (cpu_req && !cpu_done) begin
                        state <= ST_ADDR;
                        cfg <= dec_config;
                        cs_sel <= dec_cs;
                        wr_cycle <= cpu_write;
                        wdata <= cpu_wdata;
                        ale <= 1'b1;
                        segment_out <= cpu_addr[ADDR_W-1:DATA_W] & seg_mask;
                        cnt <= dec_config[CFG_ALE_BIT] ? ONE_CYC : ZERO_CYC;
                        if (dec_config[CFG_MUX_BIT]) begin
                            data_port_out <= cpu_addr[DATA_W-1:0];
                            data_port_oe <= 2'h3;
                        end else begin
                            address_port_out <= cpu_addr[DATA_W-1:0];
                        end
                        if (chip_select_timing_bit) begin
                            chip_select_lines_n <= ~dec_cs;
                        end else begin
                            cs_pending <= 1'b1;
                        end
                    end
                end
                ST_ADDR: begin
                    if (cs_pending) begin
                        // Half a CPU clock rounds up to one whole clock here.
                        chip_select_lines_n <= ~cs_sel;
                        cs_pending <= 1'b0;
                    end
                    if (cnt != ZERO_CYC) begin
                        cnt <= cnt - ONE_CYC;
                    end else begin
                        state <= ST_STROBE;
                        ale <= 1'b0;
                        cnt <= cfg[CFG_WAIT_LSB +: CNT_W];
                        strobe_dly <= cfg[CFG_RWDLY_BIT];
                        if (!cfg[CFG_RWDLY_BIT]) begin
                            rd_n <= wr_cycle;
                            wr_n <= !wr_cycle;
                        end
                        if (wr_cycle) begin
                            data_port_out <= wdata;
                            data_port_oe <= {cfg[CFG_WIDE_BIT], 1'b1};
                        end else begin
                            data_port_oe <= 2'h0;
                        end
                    end
                end
                ST_STROBE: begin
                    if (strobe_dly) begin
                        strobe_dly <= 1'b0;
                        rd_n <= wr_cycle;
                        wr_n <= !wr_cycle;
                    end else if (cnt != ZERO_CYC) begin
                        cnt <= cnt - ONE_CYC;
                    end else if (cfg[CFG_RDYEN_BIT]
                                 && (ready_sync != cfg[CFG_READY_POLARITY_BIT])) begin
                        state <= ST_STROBE;
                    end else begin
                        state <= ST_TRI;
                        rd_n <= 1'b1;
                        wr_n <= 1'b1;
                        chip_select_lines_n <= '1;
                        data_port_oe <= 2'h0;
                        cpu_done <= 1'b1;
                        if (!wr_cycle) begin
                            cpu_rdata <= cfg[CFG_WIDE_BIT] ? data_sync
                                       : {{BYTE_W{1'b0}}, data_sync[BYTE_W-1:0]};
                        end
                        cnt <= cfg[CFG_TRI_BIT] ? ONE_CYC : ZERO_CYC;
                    end
                end
                ST_TRI: begin
                    if (cnt != ZERO_CYC) begin
                        cnt <= cnt - ONE_CYC;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                ST_HOLD: begin
                    bus_request_pin_n <= !(arb_slave && cpu_req);
                    if (!hold_wanted) begin
                        // Resume only once the other master has let go.
                        state <= ST_IDLE;
                        address_port_oe <= 1'b1;
                        control_oe <= 1'b1;
                        bus_held <= 1'b0;
                        hold_ack_pin_out_n <= 1'b1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule : xbc_ext_bus_unit

// ===== logic/xbc_pkg.sv
// Shared constants for the external bus unit: widths, configuration field
// layout, address space codes and timing counts.
// Assumes a single 125 MHz clock that is also the CPU clock.
package xbc_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int SEG_W = 8;
    localparam int WIN_N = 4;
    localparam int CS_W = 5;
    localparam int CFG_W = 16;
    localparam int PAGE_W = 12;
    localparam int PAGE_SHIFT = 12;
    localparam int CNT_W = 4;
    localparam int SYNC_W = 19;

    // ------------------------------------------------------------------
    // Bus configuration word fields
    // ------------------------------------------------------------------
    localparam int CFG_MUX_BIT = 0;
    localparam int CFG_WIDE_BIT = 1;
    localparam int CFG_WAIT_LSB = 2;
    localparam int CFG_TRI_BIT = 6;
    localparam int CFG_ALE_BIT = 7;
    localparam int CFG_RWDLY_BIT = 8;
    localparam int CFG_RDYEN_BIT = 9;
    localparam int CFG_READY_POLARITY_BIT = 10;
    localparam int CFG_ENABLE_BIT = 11;

    // ------------------------------------------------------------------
    // Address space restriction and segment line masks
    // ------------------------------------------------------------------
    localparam logic [1:0] SPACE_16M = 2'h0;
    localparam logic [1:0] SPACE_1M = 2'h1;
    localparam logic [1:0] SPACE_256K = 2'h2;
    localparam logic [1:0] SPACE_64K = 2'h3;
    localparam logic [SEG_W-1:0] SEG_MASK_16M = 8'hff;
    localparam logic [SEG_W-1:0] SEG_MASK_1M = 8'h0f;
    localparam logic [SEG_W-1:0] SEG_MASK_256K = 8'h03;
    localparam logic [SEG_W-1:0] SEG_MASK_64K = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int CS_DELAY_NS = CLK_PERIOD_NS / 2;
    localparam int CS_DELAY_RAW = (CS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CS_DELAY_CYC = (CS_DELAY_RAW < 1) ? 1 : CS_DELAY_RAW;
    localparam logic [CNT_W-1:0] ONE_CYC = 4'h1;
    localparam logic [CNT_W-1:0] ZERO_CYC = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_STROBE = 3'h2,
        ST_TRI = 3'h3,
        ST_HOLD = 3'h4
    } xbc_state_t;

endpackage : xbc_pkg

// ===== logic/xbc_window_decode.sv
// Address window decoder: picks the bus configuration and chip select
// for an address.
// Assumes the range and configuration inputs are stable while decoding.
module xbc_window_decode
    import xbc_pkg::*;
(
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [WIN_N-1:0][ADDR_W-1:0] window_range_select,
    input wire logic [WIN_N-1:0][CFG_W-1:0] window_bus_config,
    input wire logic [CFG_W-1:0] default_bus_config,
    output logic [CFG_W-1:0] sel_config,
    output logic [CS_W-1:0] sel_cs
);

    // Range word: upper half is the first 4 KB page, lower half the last.
    function automatic logic in_window(input logic [ADDR_W-1:0] a,
                                       input logic [ADDR_W-1:0] range,
                                       input logic [CFG_W-1:0] cfg);
        logic [PAGE_W-1:0] page;
        page = a[ADDR_W-1:PAGE_SHIFT];
        in_window = cfg[CFG_ENABLE_BIT] && (page >= range[ADDR_W-1:PAGE_W])
                    && (page <= range[PAGE_W-1:0]);
    endfunction : in_window

    logic [WIN_N-1:0] hit;

    // ------------------------------------------------------------------
    // Window hits
    // ------------------------------------------------------------------
    generate
        for (genvar w = 0; w < WIN_N; w++) begin : g_hit
            assign hit[w] = in_window(addr, window_range_select[w], window_bus_config[w]);
        end
    endgenerate

    // Higher windows are visited last so they override lower ones.
    always_comb begin
        sel_config = default_bus_config;
        sel_cs = 5'h01;
        for (int w = 0; w < WIN_N; w++) begin
            if (hit[w]) begin
                sel_config = window_bus_config[w];
                sel_cs = CS_W'(5'h02 << w);
            end
        end
    end

endmodule : xbc_window_decode

// ===== dv/xbc_ext_bus_unit_assertions.sv
// Concurrent checks on the external bus unit's pins and CPU port.
// Assumes the unit's single clock and its asynchronous active-high reset.
module xbc_ext_bus_unit_assertions
    import xbc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic cpu_req,
    input wire logic cpu_done,
    input wire logic cpu_error,
    input wire logic single_chip,
    input wire logic [1:0] addr_space,
    input wire logic chip_select_timing_bit,
    input wire logic request_pin_direction,
    input wire logic [1:0] data_port_oe,
    input wire logic address_port_oe,
    input wire logic [SEG_W-1:0] segment_out,
    input wire logic ale,
    input wire logic [CS_W-1:0] chip_select_lines_n,
    input wire logic control_oe,
    input wire logic hold_ack_pin_out_n,
    input wire logic hold_ack_pin_oe,
    input wire logic bus_held
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [SEG_W-1:0] seg_mask;
    assign seg_mask = (addr_space == 2'h0) ? 8'hff : (addr_space == 2'h1) ? 8'h0f :
                      (addr_space == 2'h2) ? 8'h03 : 8'h00;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_addr_phase;
        $rose(ale);
    endsequence
    // A lengthened address phase keeps the latch enable up for one more cycle.
    sequence s_finish;
        ##[1:2] !ale ##[1:59] cpu_done;
    endsequence
    AST_REFUSE: assert property (single_chip && cpu_req && !cpu_done && !bus_held
        |=> cpu_done && cpu_error) else $error("single chip access not refused");
    AST_ERR_DONE: assert property (cpu_error |-> cpu_done)
        else $error("error without done");
    AST_DONE_PULSE: assert property (cpu_done |=> !cpu_done) else $error("done too long");
    AST_CS_ONE: assert property ($countones(~chip_select_lines_n) <= 1)
        else $error("several chip selects low");
    AST_CS_LATE: assert property (s_addr_phase and !chip_select_timing_bit
        |-> (&chip_select_lines_n) ##1 !(&chip_select_lines_n)) else $error("late cs timing");
    AST_CS_EARLY: assert property (s_addr_phase and chip_select_timing_bit
        |-> !(&chip_select_lines_n)) else $error("early cs timing");
    AST_SEGMENT: assert property (ale |-> (segment_out & ~seg_mask) == 8'h00)
        else $error("segment line outside space");
    AST_HOLD_FLOAT: assert property (bus_held |-> !control_oe && !address_port_oe
        && data_port_oe == 2'h0) else $error("bus driven in hold");
    AST_MASTER_ACK: assert property (bus_held && !request_pin_direction
        |-> !hold_ack_pin_out_n) else $error("hold without acknowledge");
    AST_ACK_OUT: assert property (!request_pin_direction ##1 !request_pin_direction
        |-> hold_ack_pin_oe) else $error("master acknowledge not driven");
    AST_ACK_IN: assert property (request_pin_direction ##1 request_pin_direction
        |-> !hold_ack_pin_oe) else $error("slave acknowledge driven");
    AST_ACCESS: assert property (s_addr_phase |-> s_finish)
        else $error("access did not finish");
endmodule : xbc_ext_bus_unit_assertions

bind xbc_ext_bus_unit xbc_ext_bus_unit_assertions chk_u (.clk, .reset, .cpu_req, .cpu_done,
    .cpu_error, .single_chip, .addr_space, .chip_select_timing_bit, .request_pin_direction,
    .data_port_oe, .address_port_oe, .segment_out, .ale, .chip_select_lines_n, .control_oe,
    .hold_ack_pin_out_n, .hold_ack_pin_oe, .bus_held);

// ===== dv/xbc_mem_model.sv
// Behavioural external memory on the unit's pins, with a slow ready.
// Assumes one access at a time; mux tells where the address phase travels.
module xbc_mem_model #(
    parameter int RDY_LAT = 6,
    parameter logic RDY_POL = 1'b0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic mux,
    input wire logic [15:0] address_port_out,
    input wire logic [15:0] data_port_out,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    output logic [15:0] data_port_in,
    output logic ready_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [16];
    logic [15:0] last;
    logic [3:0] idx;
    int cnt;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            idx <= 4'h0;
            last <= 16'h0;
            cnt <= 0;
        end else begin
            if (ale) idx <= mux ? data_port_out[4:1] : address_port_out[4:1];
            if (!wr_n) mem[idx] <= data_port_out;
            if (!rd_n) last <= data_port_in;
            cnt <= (rd_n && wr_n) ? 0 : cnt + 1;
        end
    end
    // A released bus shows the inverse of its last value, so stale data never matches.
    assign data_port_in = !rd_n ? mem[idx] : ~last;
    assign ready_pin = (cnt >= RDY_LAT) ? RDY_POL : !RDY_POL;
endmodule : xbc_mem_model

// ===== dv/external_bus_controller_tb.sv
// Self-checking bench: CPU accesses through every window, space, timing and hold mode.
// Assumes the design package, the memory model and the checker are compiled first.
module external_bus_controller_tb;
    import xbc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, cpu_done, cpu_error, ale, rd_n, wr_n, control_oe, ready_pin, er;
    logic bus_request_pin_n, hold_ack_pin_out_n, hold_ack_pin_oe, bus_held, address_port_oe;
    logic reset = 1'b1, cpu_req = 1'b0, cpu_write = 1'b0, single_chip = 1'b0, mux = 1'b0;
    logic chip_select_timing_bit = 1'b0, arbitration_enable = 1'b0, request_pin_direction = 1'b0;
    logic hold_n = 1'b1, hold_ack_pin_in_n = 1'b1;
    logic [1:0] addr_space = 2'h0, data_port_oe;
    logic [ADDR_W-1:0] cpu_addr = 24'h000000;
    logic [DATA_W-1:0] cpu_wdata = 16'h0000, cpu_rdata, data_port_in, data_port_out, q;
    logic [DATA_W-1:0] address_port_out;
    logic [SEG_W-1:0] segment_out, msk = 8'hff;
    logic [CS_W-1:0] chip_select_lines_n, cs;
    logic [WIN_N-1:0][ADDR_W-1:0] window_range_select = {24'h02802f, 24'h02002f, 24'h01801f,
                                                         24'h01001f};
    logic [WIN_N-1:0][CFG_W-1:0] window_bus_config = {16'h0a0e, 16'h080c, 16'h080f, 16'h080e};
    // The default region uses the long address phase, strobe delay and extra float cycle.
    logic [CFG_W-1:0] default_bus_config = 16'h01ce;
    int fail_count = 0, compares = 0, cyc = 0, n;
    logic [ADDR_W-1:0] adr [5] = '{24'h3f0002, 24'h010004, 24'h018006, 24'h020008, 24'h02800a};
    logic [DATA_W-1:0] dat [5] = '{16'h1111, 16'h2222, 16'h3333, 16'habcd, 16'h5555};
    logic [CS_W-1:0] ecs [5] = '{5'h1e, 5'h1d, 5'h1b, 5'h17, 5'h0f};
    logic [SEG_W-1:0] mtab [4] = '{8'hff, 8'h0f, 8'h03, 8'h00};
    xbc_ext_bus_unit dut_u (.clk, .reset, .cpu_req, .cpu_write, .cpu_addr, .cpu_wdata,
        .cpu_rdata, .cpu_done, .cpu_error, .single_chip, .addr_space, .chip_select_timing_bit,
        .arbitration_enable, .request_pin_direction, .window_range_select, .window_bus_config,
        .default_bus_config, .data_port_in, .data_port_out, .data_port_oe, .address_port_out,
        .address_port_oe, .segment_out, .ale, .rd_n, .wr_n, .chip_select_lines_n, .control_oe,
        .ready_pin, .hold_n, .bus_request_pin_n, .hold_ack_pin_in_n, .hold_ack_pin_out_n,
        .hold_ack_pin_oe, .bus_held);
    xbc_mem_model mem_u (.clk, .reset, .mux, .address_port_out, .data_port_out, .ale, .rd_n,
        .wr_n, .data_port_in, .ready_pin);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] s);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic seen;
        seen = 1'b0;
        repeat (3) @(negedge clk);
        cpu_req = 1'b1;
        cpu_write = w;
        cpu_addr = a;
        cpu_wdata = d;
        cs = 5'h1f;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (chip_select_lines_n !== 5'h1f) cs = chip_select_lines_n;
            if (ale === 1'b1 && !seen) begin
                seen = 1'b1;
                chk("address", a[15:0], mux ? data_port_out : address_port_out);
                chk("segment", a[23:16] & msk, segment_out);
            end
        end while (cpu_done !== 1'b1 && n < 300);
        q = cpu_rdata;
        er = cpu_error;
        cpu_req = 1'b0;
    endtask : acc
    task automatic wait_held();
        for (int k = 0; k < 20 && bus_held !== 1'b1; k++) @(negedge clk);
    endtask : wait_held
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (16) @(negedge clk);
        reset = 1'b0;
        for (int i = 0; i < 5; i++) begin
            mux = (i == 2);
            acc(1'b1, adr[i], dat[i]);
            chk("write cs", ecs[i], cs);
        end
        for (int i = 0; i < 5; i++) begin
            mux = (i == 2);
            acc(1'b0, adr[i], 16'h0000);
            chk("read cs", ecs[i], cs);
            chk("rdata", (i == 3) ? {8'h00, dat[i][7:0]} : dat[i], q);
        end
        chk("ready wait", 1, n > 8);
        $display("test windows done");
        mux = 1'b0;
        for (int s = 0; s < 4; s++) begin
            addr_space = 2'(s);
            msk = mtab[s];
            acc(1'b0, 24'hff0002, 16'h0000);
        end
        addr_space = 2'h0;
        msk = 8'hff;
        chip_select_timing_bit = 1'b1;
        acc(1'b0, adr[1], 16'h0000);
        chk("early cs", ecs[1], cs);
        chip_select_timing_bit = 1'b0;
        single_chip = 1'b1;
        acc(1'b0, adr[1], 16'h0000);
        chk("refused", 1, er);
        chk("no cs", 5'h1f, cs);
        single_chip = 1'b0;
        $display("test space timing single done");
        hold_n = 1'b0;
        repeat (6) @(negedge clk);
        chk("hold ignored", 0, bus_held);
        arbitration_enable = 1'b1;
        wait_held();
        chk("ack out", 0, hold_ack_pin_out_n);
        chk("address float", 0, address_port_oe);
        fork
            begin
                repeat (12) @(negedge clk);
                hold_n = 1'b1;
            end
        join_none
        acc(1'b0, adr[1], 16'h0000);
        chk("resume late", 1, n > 10);
        chk("resume data", dat[1], q);
        request_pin_direction = 1'b1;
        wait_held();
        chk("ack input", 0, hold_ack_pin_oe);
        fork
            begin
                repeat (8) @(negedge clk);
                chk("request", 0, bus_request_pin_n);
                hold_ack_pin_in_n = 1'b0;
            end
        join_none
        acc(1'b0, adr[0], 16'h0000);
        chk("slave data", dat[0], q);
        $display("test arbitration done");
        summarize();
    end
endmodule : external_bus_controller_tb
